// *** core/port_pin_defs.vh ***
// Purpose: Register offsets, field positions and reset values for the port pin block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Direction bit 1 means input, 0 means output
`ifndef PORT_PIN_DEFS_VH
`define PORT_PIN_DEFS_VH

`define ADDR_W 8
`define OFS_P2_DATA 8'h00
`define OFS_P2_DIR 8'h04
`define OFS_P2_PU 8'h08
`define OFS_P2_ALT 8'h0c
`define OFS_P3_DATA 8'h10
`define OFS_P3_DIR 8'h14
`define OFS_P3_PU 8'h18
`define OFS_P3_ALT 8'h1c
`define OFS_P4_DATA 8'h20
`define OFS_P4_DIR 8'h24
`define OFS_P4_PU 8'h28
`define OFS_P4_ALT 8'h2c
`define OFS_P12_DATA 8'h30
`define OFS_P12_DIR 8'h34
`define OFS_P12_PU 8'h38
`define OFS_P12_ALT 8'h3c
`define OFS_P13_DATA 8'h40
`define OFS_EDGE_RISE 8'h44
`define OFS_EDGE_FALL 8'h48
`define OFS_IRQ_STATUS 8'h4c
`define OFS_IRQ_CLEAR 8'h50
`define OFS_IRQ_ENABLE 8'h54
`define OFS_TMR_MODE 8'h58

// Port widths
`define P2_W 4
`define P3_W 2
`define P4_W 6
`define P12_W 3
`define IRQ_W 4

// Reset values: all pins input, no pull-up, port mode
`define RST_P2_DIR 4'hf
`define RST_P3_DIR 2'h3
`define RST_P4_DIR 6'h3f
`define RST_P12_DIR 3'h7

// Field positions inside alternate-mode, pull-up and timer mode registers
`define P3_ALT_TCLK 0
`define P3_ALT_TOUT 1
`define P4_ALT_IRQD 1
`define P4_ALT_TOUT 2
`define P4_ALT_TX 3
`define P4_ALT_RX 4
`define P12_ALT_OSC 0
`define P12_PU_BIT 2
`define TMR_MODE_CLK 0

`endif

// *** core/port_pin_control.v ***
// Purpose: Pin control for ports 2, 3, 4, 12 and 13 with per-bit alternate functions
// Assumes: APB slave, zero wait states, pins synchronous to pclk
// Notes:   Pin drive, enable and pull-up outputs are registered
//
// The APB interface to the registers and the register offsets were decided locally.
`include "port_pin_defs.vh"
`default_nettype none

module port_pin_control (
    input wire pclk, // APB clock, 100 MHz
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [31:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    output wire irq, // Level interrupt
    input wire [`P2_W-1:0] port2_in, // Port 2 pin levels
    output reg [`P2_W-1:0] port2_out, // Port 2 drive value
    output reg [`P2_W-1:0] port2_oe, // Port 2 drive enable
    output reg [`P2_W-1:0] port2_pullup_en, // Port 2 pull-up enable
    output reg [`P2_W-1:0] analog_channel_inputs, // Analog switch per channel
    input wire [`P3_W-1:0] port3_in, // Port 3 pin levels
    output reg [`P3_W-1:0] port3_out, // Port 3 drive value
    output reg [`P3_W-1:0] port3_oe, // Port 3 drive enable
    output reg [`P3_W-1:0] port3_pullup_en, // Port 3 pull-up enable
    input wire reset_shared_input_bit, // Input-only bit on reset pin
    input wire [`P4_W-1:0] port4_in, // Port 4 pin levels
    output reg [`P4_W-1:0] port4_out, // Port 4 drive value
    output reg [`P4_W-1:0] port4_oe, // Port 4 drive enable
    output reg [`P4_W-1:0] port4_pullup_en, // Port 4 pull-up enable
    input wire [`P12_W-1:0] port12_in, // Port 12 pin levels
    output reg [`P12_W-1:0] port12_out, // Port 12 drive value
    output reg [`P12_W-1:0] port12_oe, // Port 12 drive enable
    output reg pullup_capable_bit, // Pull-up enable of port 12 top bit
    output reg osc_in_pin, // Oscillator mode on first port 12 bit
    output reg osc_out_pin, // Oscillator mode on second port 12 bit
    output reg ext_clock, // External clock taken from first port 12 bit
    output reg output_only_bit, // Port 13 pin
    output reg [`IRQ_W-1:0] ext_irq_req, // One-cycle edge requests a..d
    input wire wide_timer_out, // 16-bit timer output
    input wire narrow_timer_out, // 8-bit timer output
    input wire serial_tx_data, // Serial transmit data
    output reg serial_rx_pin, // Serial receive data to the interface
    output reg timer_count_clock, // Count clock to the 16-bit timer
    output reg capture_reg_first_trig, // Capture trigger, first capture register
    output reg capture_reg_second_trig // Capture trigger, second capture register
);

    localparam [`P12_W-1:0] P12_PU_MASK = 3'h4;

    reg [`P2_W-1:0] port2_data;
    reg [`P2_W-1:0] port2_direction_reg;
    reg [`P2_W-1:0] port2_pullup_reg;
    reg [`P2_W-1:0] port2_alt;
    reg [`P3_W-1:0] port3_data;
    reg [`P3_W-1:0] port3_direction_reg;
    reg [`P3_W-1:0] port3_pullup_reg;
    reg [`P3_W-1:0] port3_alt;
    reg [`P4_W-1:0] port4_data;
    reg [`P4_W-1:0] port4_direction_reg;
    reg [`P4_W-1:0] port4_pullup_reg;
    reg [`P4_W-1:0] port4_alt;
    reg [`P12_W-1:0] port12_data;
    reg [`P12_W-1:0] port12_direction_reg;
    reg [`P12_W-1:0] port12_pullup_reg;
    reg [`P12_W-1:0] port12_alt;
    reg port13_data;
    reg [`IRQ_W-1:0] edge_rise;
    reg [`IRQ_W-1:0] edge_fall;
    reg [`IRQ_W-1:0] irq_status;
    reg [`IRQ_W-1:0] irq_enable;
    // Read values of the data registers, padded to one byte
    wire [7:0] p2_rd;
    wire [7:0] p3_rd;
    wire [7:0] p4_rd;
    wire [7:0] p12_rd;
    reg [`IRQ_W-1:0] irq_prev;
    reg timer_mode;
    wire [`IRQ_W-1:0] irq_now;
    wire [`IRQ_W-1:0] irq_hit;
    wire wr_en;
    wire rd_setup;
    reg [`IRQ_W-1:0] clear_mask;
    reg [31:0] next_prdata;
    reg next_slverr;
    reg [`P2_W-1:0] next_p2_oe;
    reg [`P3_W-1:0] next_p3_out, next_p3_oe;
    reg [`P4_W-1:0] next_p4_out, next_p4_oe;
    reg [`P12_W-1:0] next_p12_oe;

    // Read value of a port: pin level on input bits, latch on output bits
    function [7:0] port_read;
        input [7:0] latch;
        input [7:0] pin;
        input [7:0] dir;
        begin
            port_read = (latch & ~dir) | (pin & dir);
        end
    endfunction

    // Edge match under the selected valid edges
    function edge_match;
        input prev;
        input cur;
        input rise;
        input fall;
        begin
            edge_match = (rise & ~prev & cur) | (fall & prev & ~cur);
        end
    endfunction

    function mapped;
        input [`ADDR_W-1:0] a;
        begin
            mapped = (a[1:0] == 2'h0) && (a <= `OFS_TMR_MODE);
        end
    endfunction

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite && mapped(paddr[`ADDR_W-1:0]) && (paddr[31:`ADDR_W] == 24'h0);
    assign rd_setup = psel && !penable;

    // Alternate port 2 bits read back their latch
    assign p2_rd = port_read({4'h0, port2_data}, {4'h0, port2_in}, {4'h0, port2_direction_reg & ~port2_alt});
    assign p3_rd = port_read({6'h0, port3_data}, {6'h0, port3_in}, {6'h0, port3_direction_reg});
    assign p4_rd = port_read({2'h0, port4_data}, {2'h0, port4_in}, {2'h0, port4_direction_reg});
    assign p12_rd = port_read({5'h0, port12_data}, {5'h0, port12_in}, {5'h0, port12_direction_reg});

    // interrupt sources: a on port3 bit0, b on port4 bit3, c on port3 bit1, d on port4 bit1
    assign irq_now = {port4_in[`P4_ALT_IRQD], port3_in[1], port4_in[`P4_ALT_TX], port3_in[0]};

    genvar g;
    generate
        for (g = 0; g < `IRQ_W; g = g + 1) begin : gen_edge
            assign irq_hit[g] = edge_match(irq_prev[g], irq_now[g], edge_rise[g], edge_fall[g]);
        end
    endgenerate

    assign irq = |(irq_status & irq_enable);

    // Register read data prepared in the setup cycle
    always @* begin
        next_prdata = 32'h0;
        next_slverr = 1'b0;
        case (paddr[`ADDR_W-1:0])
            `OFS_P2_DATA: next_prdata[`P2_W-1:0] = p2_rd[`P2_W-1:0];
            `OFS_P2_DIR: next_prdata[`P2_W-1:0] = port2_direction_reg;
            `OFS_P2_PU: next_prdata[`P2_W-1:0] = port2_pullup_reg;
            `OFS_P2_ALT: next_prdata[`P2_W-1:0] = port2_alt;
            // input-only bit readable at bit 2
            `OFS_P3_DATA: next_prdata[2:0] = {reset_shared_input_bit, p3_rd[`P3_W-1:0]};
            `OFS_P3_DIR: next_prdata[`P3_W-1:0] = port3_direction_reg;
            `OFS_P3_PU: next_prdata[`P3_W-1:0] = port3_pullup_reg;
            `OFS_P3_ALT: next_prdata[`P3_W-1:0] = port3_alt;
            `OFS_P4_DATA: next_prdata[`P4_W-1:0] = p4_rd[`P4_W-1:0];
            `OFS_P4_DIR: next_prdata[`P4_W-1:0] = port4_direction_reg;
            `OFS_P4_PU: next_prdata[`P4_W-1:0] = port4_pullup_reg;
            `OFS_P4_ALT: next_prdata[`P4_W-1:0] = port4_alt;
            `OFS_P12_DATA: next_prdata[`P12_W-1:0] = p12_rd[`P12_W-1:0];
            `OFS_P12_DIR: next_prdata[`P12_W-1:0] = port12_direction_reg;
            `OFS_P12_PU: next_prdata[`P12_W-1:0] = port12_pullup_reg;
            `OFS_P12_ALT: next_prdata[1:0] = port12_alt[1:0];
            `OFS_P13_DATA: next_prdata[0] = port13_data;
            `OFS_EDGE_RISE: next_prdata[`IRQ_W-1:0] = edge_rise;
            `OFS_EDGE_FALL: next_prdata[`IRQ_W-1:0] = edge_fall;
            `OFS_IRQ_STATUS: next_prdata[`IRQ_W-1:0] = irq_status;
            `OFS_IRQ_CLEAR: next_prdata = 32'h0;
            `OFS_IRQ_ENABLE: next_prdata[`IRQ_W-1:0] = irq_enable;
            `OFS_TMR_MODE: next_prdata[0] = timer_mode;
            default: next_slverr = 1'b1;
        endcase
        if (paddr[31:`ADDR_W] != 24'h0) begin
            next_prdata = 32'h0;
            next_slverr = 1'b1;
        end
    end

    // APB read data and error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? 32'h0 : next_prdata;
            pslverr <= next_slverr;
        end
    end

    // async active-low reset of all settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_data <= 4'h0;
            port3_data <= 2'h0;
            port4_data <= 6'h0;
            port12_data <= 3'h0;
            port13_data <= 1'b0;
            port2_direction_reg <= `RST_P2_DIR;
            port3_direction_reg <= `RST_P3_DIR;
            port4_direction_reg <= `RST_P4_DIR;
            port12_direction_reg <= `RST_P12_DIR;
            port2_pullup_reg <= 4'h0;
            port3_pullup_reg <= 2'h0;
            port4_pullup_reg <= 6'h0;
            port12_pullup_reg <= 3'h0;
            port2_alt <= 4'h0;
            port3_alt <= 2'h0;
            port4_alt <= 6'h0;
            port12_alt <= 3'h0;
            edge_rise <= 4'h0;
            edge_fall <= 4'h0;
            irq_enable <= 4'h0;
            timer_mode <= 1'b0;
        end else if (wr_en) begin
            case (paddr[`ADDR_W-1:0])
                `OFS_P2_DATA: port2_data <= pwdata[`P2_W-1:0];
                `OFS_P2_DIR: port2_direction_reg <= pwdata[`P2_W-1:0];
                `OFS_P2_PU: port2_pullup_reg <= pwdata[`P2_W-1:0];
                `OFS_P2_ALT: port2_alt <= pwdata[`P2_W-1:0];
                `OFS_P3_DATA: port3_data <= pwdata[`P3_W-1:0];
                `OFS_P3_DIR: port3_direction_reg <= pwdata[`P3_W-1:0];
                `OFS_P3_PU: port3_pullup_reg <= pwdata[`P3_W-1:0];
                `OFS_P3_ALT: port3_alt <= pwdata[`P3_W-1:0];
                `OFS_P4_DATA: port4_data <= pwdata[`P4_W-1:0];
                `OFS_P4_DIR: port4_direction_reg <= pwdata[`P4_W-1:0];
                `OFS_P4_PU: port4_pullup_reg <= pwdata[`P4_W-1:0];
                `OFS_P4_ALT: port4_alt <= pwdata[`P4_W-1:0];
                `OFS_P12_DATA: port12_data <= pwdata[`P12_W-1:0];
                `OFS_P12_DIR: port12_direction_reg <= pwdata[`P12_W-1:0];
                // only the top bit holds a pull-up
                `OFS_P12_PU: port12_pullup_reg <= pwdata[`P12_W-1:0] & P12_PU_MASK;
                `OFS_P12_ALT: port12_alt <= {1'b0, pwdata[1:0]};
                `OFS_P13_DATA: port13_data <= pwdata[0];
                `OFS_EDGE_RISE: edge_rise <= pwdata[`IRQ_W-1:0];
                `OFS_EDGE_FALL: edge_fall <= pwdata[`IRQ_W-1:0];
                `OFS_IRQ_ENABLE: irq_enable <= pwdata[`IRQ_W-1:0];
                `OFS_TMR_MODE: timer_mode <= pwdata[`TMR_MODE_CLK];
                default: timer_mode <= timer_mode;
            endcase
        end
    end

    always @* begin
        clear_mask = 4'h0;
        if (wr_en && paddr[`ADDR_W-1:0] == `OFS_IRQ_CLEAR) begin
            clear_mask = pwdata[`IRQ_W-1:0];
        end
    end

    // sticky status, a new edge wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev <= 4'h0;
            irq_status <= 4'h0;
            ext_irq_req <= 4'h0;
        end else begin
            irq_prev <= irq_now;
            irq_status <= (irq_status & ~clear_mask) | irq_hit;
            ext_irq_req <= irq_hit;
        end
    end

    // Pin drive selection for the next cycle
    always @* begin
        // analog mode releases the digital driver
        next_p2_oe = ~port2_direction_reg & ~port2_alt;
        // port 3 driven per direction bit
        next_p3_out = port3_data;
        next_p3_oe = ~port3_direction_reg;
        // wide timer output replaces the latch on port 3 bit1
        if (port3_alt[`P3_ALT_TOUT]) begin
            next_p3_out[1] = wide_timer_out;
        end
        // port 4 driven per direction bit
        next_p4_out = port4_data;
        next_p4_oe = ~port4_direction_reg;
        // narrow timer output on port 4 bit2
        if (port4_alt[`P4_ALT_TOUT]) begin
            next_p4_out[`P4_ALT_TOUT] = narrow_timer_out;
        end
        // transmit data, still gated by the direction bit
        if (port4_alt[`P4_ALT_TX]) begin
            next_p4_out[`P4_ALT_TX] = serial_tx_data;
        end
        // receive pin never driven in alternate mode
        if (port4_alt[`P4_ALT_RX]) begin
            next_p4_oe[`P4_ALT_RX] = 1'b0;
        end
        next_p12_oe = ~port12_direction_reg & ~{1'b0, port12_alt[1:0]};
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_out <= 4'h0;
            port2_oe <= 4'h0;
            port2_pullup_en <= 4'h0;
            analog_channel_inputs <= 4'h0;
            port3_out <= 2'h0;
            port3_oe <= 2'h0;
            port3_pullup_en <= 2'h0;
            port4_out <= 6'h0;
            port4_oe <= 6'h0;
            port4_pullup_en <= 6'h0;
            port12_out <= 3'h0;
            port12_oe <= 3'h0;
            pullup_capable_bit <= 1'b0;
            osc_in_pin <= 1'b0;
            osc_out_pin <= 1'b0;
            ext_clock <= 1'b0;
            output_only_bit <= 1'b0;
            serial_rx_pin <= 1'b1;
            timer_count_clock <= 1'b0;
            capture_reg_first_trig <= 1'b0;
            capture_reg_second_trig <= 1'b0;
        end else begin
            port2_out <= port2_data;
            port2_oe <= next_p2_oe;
            // pull-up per register bit, only on digital pins
            port2_pullup_en <= port2_pullup_reg & port2_direction_reg & ~port2_alt;
            analog_channel_inputs <= port2_alt;
            port3_out <= next_p3_out;
            port3_oe <= next_p3_oe;
            port3_pullup_en <= port3_pullup_reg & port3_direction_reg;
            port4_out <= next_p4_out;
            port4_oe <= next_p4_oe;
            port4_pullup_en <= port4_pullup_reg & port4_direction_reg;
            port12_out <= port12_data;
            port12_oe <= next_p12_oe;
            // single pull-up on the top bit
            pullup_capable_bit <= port12_pullup_reg[`P12_PU_BIT] & port12_direction_reg[`P12_PU_BIT];
            osc_in_pin <= port12_alt[0];
            osc_out_pin <= port12_alt[1];
            ext_clock <= port12_alt[0] & port12_in[0];
            output_only_bit <= port13_data;
            serial_rx_pin <= port4_alt[`P4_ALT_RX] ? port4_in[`P4_ALT_RX] : 1'b1;
            // count clock or capture on both registers
            timer_count_clock <= port3_alt[`P3_ALT_TCLK] & timer_mode & port3_in[0];
            // second timer pin triggers first capture only
            capture_reg_first_trig <= (port3_alt[`P3_ALT_TCLK] & ~timer_mode & port3_in[0])
                | (port3_alt[`P3_ALT_TOUT] & port3_direction_reg[1] & port3_in[1]);
            capture_reg_second_trig <= port3_alt[`P3_ALT_TCLK] & ~timer_mode & port3_in[0];
        end
    end

endmodule // port_pin_control

`default_nettype wire

// *** test/pin_model.sv ***
// Purpose: Pin level model for one port: module drive, outside drive, pull-up
// Assumes: Outside drive values come from the bench, one clock
// Notes:   An undriven pin with no pull-up toggles every cycle
`default_nettype none
module pin_model #(parameter int W = 4) (
    input wire logic clk, // Bench clock
    input wire logic [W-1:0] oe, // Module drive enable
    input wire logic [W-1:0] out, // Module drive value
    input wire logic [W-1:0] pu, // Pull-up enable
    input wire logic [W-1:0] ext_en, // Outside drive enable
    input wire logic [W-1:0] ext_val, // Outside drive value
    output logic [W-1:0] level // Resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] wobble = '0;
    always @(posedge clk) begin
        wobble <= ~wobble;
    end
    assign level = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | wobble));
endmodule // pin_model
`default_nettype wire

// *** test/port_pin_props.sv ***
// Purpose: Concurrent checks on the port pin block outputs
// Assumes: Bound to port_pin_control, one clock domain
// Notes:   Only top-level ports are observed
`include "port_pin_defs.vh"
`default_nettype none
module port_pin_props (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic [`P2_W-1:0] port2_oe, // P2 enable
    input wire logic [`P2_W-1:0] port2_pullup_en, // P2 pull-up
    input wire logic [`P2_W-1:0] analog_channel_inputs, // Analog switches
    input wire logic [`P3_W-1:0] port3_in, // P3 pins
    input wire logic [`P3_W-1:0] port3_oe, // P3 enable
    input wire logic [`P3_W-1:0] port3_pullup_en, // P3 pull-up
    input wire logic [`P4_W-1:0] port4_in, // P4 pins
    input wire logic [`P4_W-1:0] port4_oe, // P4 enable
    input wire logic [`P4_W-1:0] port4_pullup_en, // P4 pull-up
    input wire logic [`P12_W-1:0] port12_in, // P12 pins
    input wire logic [`P12_W-1:0] port12_oe, // P12 enable
    input wire logic osc_in_pin, // Osc bit 0
    input wire logic osc_out_pin, // Osc bit 1
    input wire logic ext_clock, // External clock
    input wire logic [`IRQ_W-1:0] ext_irq_req, // Edge requests
    input wire logic serial_rx_pin, // Serial receive
    input wire logic timer_count_clock, // Count clock
    input wire logic capture_reg_second_trig // Second capture
);
    logic [3:0] src;
    assign src = {port4_in[1], port3_in[1], port4_in[3], port3_in[0]};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence osc_steady;
        osc_in_pin [*2];
    endsequence
    a_pullup_input_only: assert property (((port2_pullup_en & port2_oe) | ((port3_pullup_en & port3_oe) << 2)
        | ((port4_pullup_en & port4_oe) << 4)) == 10'h0) else $error("pull-up on a driven bit");
    a_analog_not_driven: assert property ((analog_channel_inputs & port2_oe) == 4'h0)
        else $error("analog channel pin driven");
    a_osc_not_driven: assert property ((osc_in_pin || osc_out_pin) |-> (port12_oe[1:0] & {osc_out_pin, osc_in_pin}) == 2'h0)
        else $error("oscillator pin driven");
    a_ext_clock_copy: assert property (osc_steady |-> ext_clock == $past(port12_in[0]))
        else $error("external clock does not follow pin");
    a_edge_has_cause: assert property ((ext_irq_req & ~(($past(src) ^ $past(src, 2)) | ($past(src, 2) ^ $past(src, 3)))) == 4'h0)
        else $error("edge request without pin change");
    a_rx_follows_pin: assert property (!serial_rx_pin |-> !$past(port4_in[4]))
        else $error("serial receive low without pin low");
    a_second_capture_src: assert property (capture_reg_second_trig |-> $past(port3_in[0]))
        else $error("second capture trigger without first timer pin");
    a_clock_or_capture: assert property (timer_count_clock |-> $past(port3_in[0]) && !capture_reg_second_trig)
        else $error("count clock wrong");
    c_edge_seen: cover property (ext_irq_req[0]);
endmodule // port_pin_props
bind port_pin_control port_pin_props u_props (.*);
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the port pin block
// Assumes: APB master tasks, a pin model on every I/O port
// Notes:   Random data from seed 59 with fixed corner cases
`include "port_pin_defs.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0;
    logic [3:0] x2 = 4'h0;
    logic [1:0] x3 = 2'h0;
    logic [5:0] x4 = 6'h0;
    logic [2:0] x12 = 3'h0;
    logic rsb = 1'b0, wto = 1'b0, nto = 1'b0, std = 1'b0, xen = 1'b1;
    wire [31:0] prdata;
    wire pready, pslverr, irq, osc_in_pin, osc_out_pin, ext_clock, output_only_bit, serial_rx_pin;
    wire pullup_capable_bit, timer_count_clock, capture_reg_first_trig, capture_reg_second_trig;
    wire [3:0] port2_in, port2_out, port2_oe, port2_pullup_en, analog_channel_inputs, ext_irq_req;
    wire [1:0] port3_in, port3_out, port3_oe, port3_pullup_en;
    wire [5:0] port4_in, port4_out, port4_oe, port4_pullup_en;
    wire [2:0] port12_in, port12_out, port12_oe;
    int err_total = 0;
    int n_compared = 0;
    port_pin_control u_port_pin_control (.*, .reset_shared_input_bit(rsb), .wide_timer_out(wto),
        .narrow_timer_out(nto), .serial_tx_data(std));
    pin_model #(.W(4)) u_pin2 (.clk(pclk), .oe(port2_oe), .out(port2_out), .pu(port2_pullup_en),
        .ext_en({4{xen}}), .ext_val(x2), .level(port2_in));
    pin_model #(.W(2)) u_pin3 (.clk(pclk), .oe(port3_oe), .out(port3_out), .pu(port3_pullup_en),
        .ext_en({2{xen}}), .ext_val(x3), .level(port3_in));
    pin_model #(.W(6)) u_pin4 (.clk(pclk), .oe(port4_oe), .out(port4_out), .pu(port4_pullup_en),
        .ext_en({6{xen}}), .ext_val(x4), .level(port4_in));
    pin_model #(.W(3)) u_pin12 (.clk(pclk), .oe(port12_oe), .out(port12_out), .pu({pullup_capable_bit, 2'b00}),
        .ext_en({3{xen}}), .ext_val(x12), .level(port12_in));
    always #5 pclk = ~pclk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) err_total++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, q, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic [31:0] mask(input int i);
        return (i == 0) ? 32'hf : (i == 1) ? 32'h3 : (i == 2) ? 32'h3f : 32'h7;
    endfunction
    function automatic logic [31:0] pick(input int i, input int k);
        logic [31:0] v [4][3];
        v = '{'{32'(port2_oe), 32'(port2_out), 32'(port2_pullup_en)}, '{32'(port3_oe), 32'(port3_out),
            32'(port3_pullup_en)}, '{32'(port4_oe), 32'(port4_out), 32'(port4_pullup_en)},
            '{32'(port12_oe), 32'(port12_out), {29'h0, pullup_capable_bit, 2'b00}}};
        return v[i][k];
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200us;
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] dat, dir, pu, xv, m, q;
        logic e;
        void'($urandom(59));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        check("oe after reset", {port2_oe, port3_oe, port4_oe, port12_oe}, 32'h0);
        check("rx idle", serial_rx_pin, 1'b1);
        for (int i = 0; i < 4; i++) begin
            rdchk(32'(i * 16 + 4), mask(i), "dir reset");
        end
        apb(1'b0, 32'h5c, 32'h0, q, e);
        check("unmapped err", e, 1'b1);
        for (int r = 0; r < 12; r++) begin
            for (int i = 0; i < 4; i++) begin
                m = mask(i);
                dat = $urandom & m;
                dir = (r == 0) ? 32'h0 : (r == 1) ? m : $urandom & m;
                pu = $urandom & m;
                xv = $urandom;
                x2 <= xv[3:0];
                x3 <= xv[1:0];
                x4 <= xv[5:0];
                x12 <= xv[2:0];
                rsb <= xv[8];
                wr(32'(i * 16), dat);
                wr(32'(i * 16 + 4), dir);
                wr(32'(i * 16 + 8), pu);
                tick(2);
                check("oe", pick(i, 0), ~dir & m);
                check("out", pick(i, 1) & ~dir, dat & ~dir);
                check("pullup", pick(i, 2), pu & dir & ((i == 3) ? 32'h4 : m));
                rdchk(32'(i * 16), (dat & ~dir) | (xv & dir & m) | ((i == 1) ? {xv[8], 2'b00} : 0), "data");
            end
        end
        dat = $urandom & 32'hf;
        wr(`OFS_P2_ALT, dat);
        tick(2);
        check("analog", analog_channel_inputs, dat);
        wr(`OFS_P3_DIR, 32'h1);
        wr(`OFS_P3_ALT, 32'h3);
        wr(`OFS_P4_DIR, 32'h33);
        wr(`OFS_P4_ALT, 32'h1c);
        for (int v = 0; v < 4; v++) begin
            wto <= v[0];
            nto <= v[1];
            std <= v[0];
            x4[4] <= v[1];
            tick(2);
            check("wide out", {port3_oe[1], port3_out[1]}, {1'b1, v[0]});
            check("narrow out", {port4_oe[2], port4_out[2]}, {1'b1, v[1]});
            check("tx", {port4_oe[3], port4_out[3], port4_oe[4]}, {1'b1, v[0], 1'b0});
            check("rx", serial_rx_pin, v[1]);
        end
        wr(`OFS_P12_ALT, 32'h3);
        for (int v = 1; v >= 0; v--) begin
            x12[0] <= v[0];
            tick(3);
            check("osc", {osc_in_pin, osc_out_pin, port12_oe[1:0], ext_clock}, {4'hc, v[0]});
        end
        for (int v = 0; v < 2; v++) begin
            wr(`OFS_P13_DATA, v);
            tick(2);
            check("p13", output_only_bit, v);
        end
        wr(`OFS_TMR_MODE, 32'h1);
        x3[0] <= 1'b1;
        tick(3);
        check("count clock", {timer_count_clock, capture_reg_second_trig}, 2'h2);
        wr(`OFS_TMR_MODE, 32'h0);
        tick(2);
        check("captures", {timer_count_clock, capture_reg_first_trig, capture_reg_second_trig}, 3'h3);
        wr(`OFS_IRQ_ENABLE, 32'h1);
        for (int md = 1; md < 4; md++) begin
            wr(`OFS_EDGE_RISE, md & 1);
            wr(`OFS_EDGE_FALL, md >> 1);
            x3[0] <= 1'b0;
            tick(3);
            wr(`OFS_IRQ_CLEAR, 32'hf);
            x3[0] <= 1'b1;
            tick(3);
            rdchk(`OFS_IRQ_STATUS, md & 1, "status rise");
            check("irq rise", irq, md & 1);
            wr(`OFS_IRQ_CLEAR, 32'h1);
            x3[0] <= 1'b0;
            tick(3);
            rdchk(`OFS_IRQ_STATUS, md >> 1, "status fall");
        end
        wr(`OFS_IRQ_ENABLE, 32'h0);
        tick(2);
        check("irq masked", irq, 1'b0);
        wr(`OFS_IRQ_ENABLE, 32'h1);
        tick(2);
        check("irq enabled", irq, 1'b1);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        tick(2);
        check("irq cleared", irq, 1'b0);
        rdchk(`OFS_IRQ_CLEAR, 32'h0, "clear reads zero");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
